// ### rtl/eeprom_pkg.sv
// package of constants and types for the two-wire eeprom write port
// assumes a single 250 MHz core clock; every time becomes a cycle count

package eeprom_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS     = 1000000;
  localparam int TW_NORMAL_MS  = 10;
  localparam int TW_LONG_MS    = 20;
  // longest times, so they round down
  localparam int TW_NORMAL_CYC = TW_NORMAL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TW_LONG_CYC   = TW_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TMR_W         = 23;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int BYTE_W     = 8;
  localparam int BLK_W      = 3;
  localparam int CODE_W     = 4;
  localparam int CODE_LSB   = 4;
  localparam int BLK_LSB    = 1;
  localparam int ROW_LSB    = 4;
  localparam int MEM_ADDR_W = BLK_W + BYTE_W;
  localparam int WORD_W     = MEM_ADDR_W + BYTE_W;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // reset values and identity
  // ----------------------------------------------------------------
  localparam logic MODE_RST = 1'b1;
  localparam logic WI_RST   = 1'b0;
  // arbitrary neutral device type code
  localparam logic [CODE_W-1:0] DEV_CODE_DEFAULT = 4'h6;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_PROG} dev_state_t;
  typedef enum logic [1:0] {PH_SEL, PH_ADDR, PH_DATA} phase_t;

endpackage

// ### rtl/eeprom_write_port.sv
// two-wire slave write path of a serial eeprom, with program cycle
// assumes scl, sda and the straps are asynchronous pins; memory
// array sits outside and takes words through mem_wr_*
//
// Operation
// - device is slave only, master clocks
// - start is sda fall, scl high
// - stop is sda rise, scl high; ends talk
// - stop after read goes to standby
// - stop after write starts timed program
// - receiver pulls sda low on ninth clock
// - sample sda on each scl rising edge
// - select byte: code, block bits, direction
// - mode high multibyte, low page write
// - acknowledge select then byte address
// - inhibit high blocks data, withholds acks
// - byte write: one byte then stop
// - multibyte: one to eight bytes, any address
// - row crossing multibyte doubles program time
// - page write: up to sixteen, one row
// - page address wraps in low four bits
// - ignore bus during program cycle
// - device detaches while programming, master polls
// - busy device leaves select unacknowledged
// - unconnected inhibit reads as low
// - unconnected mode reads as high

module eeprom_write_port
  import eeprom_pkg::*;
#(
  parameter logic [CODE_W-1:0] DEV_CODE       = DEV_CODE_DEFAULT,
  parameter bit                WC_VARIANT     = 1'b0,
  parameter int                TW_CYCLES      = TW_NORMAL_CYC,
  parameter int                TW_LONG_CYCLES = TW_LONG_CYC,
  parameter int                DEPTH          = FIFO_DEPTH
) (
  input  wire logic                               clk,
  input  wire logic                               arst_n,
  input  wire logic                               scl_i,
  input  wire logic                               sda_i,
  output logic                                    sda_o,
  output logic                                    sda_oe,
  input  wire logic                               mode_i,
  input  wire logic                               write_inhibit_input,
  output logic                                    mem_wr_valid,
  input  wire logic                               mem_wr_ready,
  output logic [eeprom_pkg::MEM_ADDR_W-1:0]       mem_wr_addr,
  output logic [eeprom_pkg::BYTE_W-1:0]           mem_wr_data,
  output logic                                    busy
);
  import eeprom_pkg::*;

  typedef struct packed {
    dev_state_t          st;
    phase_t              ph;
    logic                scl_m;
    logic                scl_s;
    logic                scl_p;
    logic                sda_m;
    logic                sda_s;
    logic                sda_p;
    logic                mode_m;
    logic                mode_s;
    logic                wi_m;
    logic                wi_s;
    logic [BYTE_W-1:0]   shift;
    logic [3:0]          bitcnt;
    logic                is_write;
    logic                inhibit;
    logic                page;
    logic [BLK_W-1:0]    blk;
    logic [BYTE_W-1:0]   addr;
    logic [BLK_W+3:0]    start_row;
    logic                long_cyc;
    logic                wr_pending;
    logic [TMR_W-1:0]    timer;
    logic                sda_lvl;
    logic                sda_oe;
    logic                busy;
    logic                mem_valid;
    logic [WORD_W-1:0]   mem_word;
  } port_state_t;

  // ----------------------------------------------------------------
  // reset image
  // ----------------------------------------------------------------
  // pin synchronisers rest at the level an open strap reads as
  localparam port_state_t RST = '{
    st: ST_IDLE, ph: PH_SEL,
    scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
    mode_m: MODE_RST, mode_s: MODE_RST,
    wi_m: WI_RST, wi_s: WI_RST,
    default: '0
  };

  port_state_t q;
  port_state_t d;

  stream_if #(.W(WORD_W)) wr_ch ();
  stream_if #(.W(WORD_W)) rd_ch ();

  word_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk    (clk),
    .arst_n (arst_n),
    .in_s   (wr_ch.sink),
    .out_s  (rd_ch.source)
  );

  // ----------------------------------------------------------------
  // bus events seen through the synchronisers
  // ----------------------------------------------------------------
  logic start_evt;
  logic stop_evt;
  logic scl_rise;
  logic scl_fall;
  logic byte_end;
  logic code_ok;

  // only the second stage and its delayed copy are looked at
  assign start_evt = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
  assign stop_evt  = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
  assign scl_rise  = q.scl_s && !q.scl_p;
  assign scl_fall  = !q.scl_s && q.scl_p;
  assign byte_end  = (q.st == ST_RECV) && scl_fall &&
                     (q.bitcnt == BITS_PER_BYTE);
  assign code_ok   = (q.shift[CODE_LSB +: CODE_W] == DEV_CODE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // two-stage synchronisers, plus a delayed copy for edges
    d.scl_m  = scl_i;
    d.scl_s  = q.scl_m;
    d.scl_p  = q.scl_s;
    d.sda_m  = sda_i;
    d.sda_s  = q.sda_m;
    d.sda_p  = q.sda_s;
    d.mode_m = mode_i;
    d.mode_s = q.mode_m;
    d.wi_m   = write_inhibit_input;
    d.wi_s   = q.wi_m;
    d.sda_lvl = 1'b0;

    // drain latched words into the array only while programming
    wr_ch.valid = 1'b0;
    wr_ch.data  = {q.blk, q.addr, q.shift};
    rd_ch.ready = (q.st == ST_PROG) && (!q.mem_valid || mem_wr_ready);
    if (q.mem_valid && mem_wr_ready) begin
      d.mem_valid = 1'b0;
    end
    if (rd_ch.valid && rd_ch.ready) begin
      d.mem_valid = 1'b1;
      d.mem_word  = rd_ch.data;
    end

    if (q.st == ST_PROG) begin
      // bus is not watched here, so polls get no ack
      d.sda_oe = 1'b0;
      if (q.timer != '0) begin
        d.timer = q.timer - 1'b1;
      end else if (!rd_ch.valid && !q.mem_valid) begin
        d.st   = ST_IDLE;
        d.busy = 1'b0;
      end
    end else if (start_evt) begin
      // also a repeated start; words already latched stay pending
      d.st      = ST_RECV;
      d.ph      = PH_SEL;
      d.bitcnt  = '0;
      d.sda_oe  = 1'b0;
      d.inhibit = WC_VARIANT && q.wi_s;
      d.page    = WC_VARIANT || !q.mode_s;
    end else if (stop_evt) begin
      d.sda_oe = 1'b0;
      if (q.wr_pending) begin
        // long count only when a multibyte burst left its row
        d.st    = ST_PROG;
        d.busy  = 1'b1;
        d.timer = q.long_cyc ? TMR_W'(TW_LONG_CYCLES - 1)
                             : TMR_W'(TW_CYCLES - 1);
        d.wr_pending = 1'b0;
        d.long_cyc   = 1'b0;
      end else begin
        d.st = ST_IDLE;
      end
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ST_RECV: begin
          if (WC_VARIANT && q.wi_s && q.ph != PH_DATA) begin
            d.inhibit = 1'b1;
          end
          if (scl_rise && q.bitcnt != BITS_PER_BYTE) begin
            d.shift  = {q.shift[BYTE_W-2:0], q.sda_s};
            d.bitcnt = q.bitcnt + 1'b1;
          end
          if (byte_end) begin
            d.st = ST_ACK;
            unique case (q.ph)
              PH_SEL: begin
                // read direction belongs to the read path
                if (!code_ok || q.shift[0]) begin
                  d.st = ST_IDLE;
                end else begin
                  d.is_write = 1'b1;
                  d.blk      = q.shift[BLK_LSB +: BLK_W];
                  d.ph       = PH_ADDR;
                  d.sda_oe   = 1'b1;
                end
              end
              PH_ADDR: begin
                d.addr      = q.shift;
                d.start_row = {q.blk, q.shift[BYTE_W-1:ROW_LSB]};
                d.ph        = PH_DATA;
                d.sda_oe    = 1'b1;
                if (WC_VARIANT && q.wi_s) begin
                  d.inhibit = 1'b1;
                end
              end
              PH_DATA: begin
                if (!q.inhibit) begin
                  wr_ch.valid = 1'b1;
                end
                // full buffer refuses the byte by withholding ack
                if (!q.inhibit && wr_ch.ready) begin
                  d.sda_oe     = 1'b1;
                  d.wr_pending = 1'b1;
                  if (q.page) begin
                    d.addr[ROW_LSB-1:0] = q.addr[ROW_LSB-1:0] + 1'b1;
                  end else begin
                    d.addr = q.addr + 1'b1;
                  end
                  if (!q.page &&
                      {q.blk, q.addr[BYTE_W-1:ROW_LSB]} != q.start_row) begin
                    d.long_cyc = 1'b1;
                  end
                end
              end
              default: begin
                d.st = ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          // hold the ninth bit through its whole high phase
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = '0;
            d.st     = ST_RECV;
          end
        end
        ST_PROG: begin
          d.st = ST_PROG;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // outputs, each straight from a register
  assign sda_o        = q.sda_lvl;
  assign sda_oe       = q.sda_oe;
  assign busy         = q.busy;
  assign mem_wr_valid = q.mem_valid;
  assign mem_wr_addr  = q.mem_word[WORD_W-1:BYTE_W];
  assign mem_wr_data  = q.mem_word[BYTE_W-1:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_drive_only_ack;
    @(posedge clk) disable iff (!arst_n)
    q.sda_oe |-> (q.st == ST_ACK) && !q.sda_lvl;
  endproperty
  a_drive_only_ack: assert property (p_drive_only_ack)
    else $error("sda driven outside an acknowledge slot");

  property p_quiet_in_prog;
    @(posedge clk) disable iff (!arst_n)
    (q.st == ST_PROG) |-> !q.sda_oe && q.busy;
  endproperty
  a_quiet_in_prog: assert property (p_quiet_in_prog)
    else $error("device answered during program cycle");

  property p_stop_programs;
    @(posedge clk) disable iff (!arst_n)
    stop_evt && q.st != ST_PROG && q.wr_pending
      |=> q.st == ST_PROG ##1 q.st == ST_PROG;
  endproperty
  a_stop_programs: assert property (p_stop_programs)
    else $error("stop after write did not start program cycle");

  property p_stop_standby;
    @(posedge clk) disable iff (!arst_n)
    stop_evt && q.st != ST_PROG && !q.wr_pending |=> q.st == ST_IDLE;
  endproperty
  a_stop_standby: assert property (p_stop_standby)
    else $error("stop without data did not return to standby");

  property p_start_arms;
    @(posedge clk) disable iff (!arst_n)
    start_evt && q.st != ST_PROG
      |=> q.st == ST_RECV && q.bitcnt == '0 && q.ph == PH_SEL;
  endproperty
  a_start_arms: assert property (p_start_arms)
    else $error("start did not arm select byte reception");

  property p_sample_rise;
    @(posedge clk) disable iff (!arst_n)
    q.st == ST_RECV && scl_rise && q.bitcnt != BITS_PER_BYTE
      && !start_evt && !stop_evt
      |=> q.shift[0] == $past(q.sda_s) && q.bitcnt == $past(q.bitcnt) + 1;
  endproperty
  a_sample_rise: assert property (p_sample_rise)
    else $error("bit not sampled on scl rising edge");

  property p_page_wrap;
    @(posedge clk) disable iff (!arst_n)
    wr_ch.valid && wr_ch.ready && q.page
      |=> q.addr[BYTE_W-1:ROW_LSB] == $past(q.addr[BYTE_W-1:ROW_LSB]);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page address left its row");

  property p_inhibit_blocks;
    @(posedge clk) disable iff (!arst_n)
    byte_end && q.ph == PH_DATA && q.inhibit
      && !start_evt && !stop_evt |-> !wr_ch.valid ##1 !q.sda_oe;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks)
    else $error("inhibited data byte was latched or acknowledged");

  property p_foreign_code;
    @(posedge clk) disable iff (!arst_n)
    byte_end && q.ph == PH_SEL && !code_ok && !start_evt && !stop_evt
      |=> q.st == ST_IDLE && !q.sda_oe;
  endproperty
  a_foreign_code: assert property (p_foreign_code)
    else $error("foreign device code was answered");

  property p_ack_held;
    @(posedge clk) disable iff (!arst_n)
    $rose(q.sda_oe) |-> q.sda_oe [*3];
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("acknowledge released too early");

endmodule

// ### rtl/stream_if.sv
// valid/ready word channel between the port logic and its fifo
// assumes both ends run on the same clock

interface stream_if #(
  parameter int W = 8
) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// ### rtl/word_fifo.sv
// synchronous fifo with registered read data
// assumes DEPTH is a power of two and one clock for both sides

module word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  stream_if.sink   in_s,
  stream_if.source out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // output register refills as soon as it empties or is taken
  always_comb begin
    d = q;
    in_s.ready = (q.cnt != CNT_FULL);
    push = in_s.valid && in_s.ready;
    pop = (q.cnt != '0) && (!q.ov || out_s.ready);
    if (q.ov && out_s.ready) begin
      d.ov = 1'b0;
    end
    if (pop) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = in_s.data;
      d.wp = q.wp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_s.valid = q.ov;
  assign out_s.data  = q.od;
endmodule

// ### verification/eeprom_write_port_tb.sv
// self-checking bench for the two-wire eeprom write port
// assumes the master model two_wire_master and a pull-up on sda

module eeprom_write_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;

  // program times cut short, yet long enough for a poll to land
  localparam int TW_N  = 600;
  localparam int TW_L  = 1200;
  localparam int SLACK = 30;

  logic                  clk, arst_n, mode_i, wi, mem_wr_ready;
  logic                  scl, sda_m, sda_o, sda_oe, busy, mem_wr_valid;
  logic [MEM_ADDR_W-1:0] mem_wr_addr;
  logic [BYTE_W-1:0]     mem_wr_data;
  logic [WORD_W-1:0]     exp_q[$];
  logic [7:0]            dat_s = 8'h3f;
  logic [7:0]            rdy_s = 8'h3f;
  int                    err_count, n_checks, bcnt, blen;
  wire                   sda_w;

  // pull-up wins unless someone pulls low
  assign sda_w = sda_m & ~sda_oe;

  eeprom_write_port #(
    .TW_CYCLES      (TW_N),
    .TW_LONG_CYCLES (TW_L)
  ) dut (
    .clk                 (clk),
    .arst_n              (arst_n),
    .scl_i               (scl),
    .sda_i               (sda_w),
    .sda_o               (sda_o),
    .sda_oe              (sda_oe),
    .mode_i              (mode_i),
    .write_inhibit_input (wi),
    .mem_wr_valid        (mem_wr_valid),
    .mem_wr_ready        (mem_wr_ready),
    .mem_wr_addr         (mem_wr_addr),
    .mem_wr_data         (mem_wr_data),
    .busy                (busy)
  );

  two_wire_master m (
    .scl   (scl),
    .sda_m (sda_m),
    .sda   (sda_w)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [WORD_W-1:0] e,
                          input logic [WORD_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_int(input string n, input int e, input int g);
    n_checks++;
    if (g != e) begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // clock; array side stalls at random so the fifo backs up
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    rdy_s = lfsr(rdy_s);
    mem_wr_ready <= #1 rdy_s[0];
  end

  // array words against the model queue, busy span, drive polarity
  always @(posedge clk) begin
    if (sda_oe === 1'b1)
      chk_bit("sda_o_low", 1'b0, sda_o);
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      chk_bit("word_in_busy", 1'b1, busy);
      if (exp_q.size() == 0)
        chk_int("extra_word", 0, 1);
      else
        chk_word("mem_word", exp_q.pop_front(),
                 {mem_wr_addr, mem_wr_data});
    end
    if (busy === 1'b1)
      bcnt++;
    else if (bcnt > 0) begin
      blen = bcnt;
      bcnt = 0;
    end
  end

  // ----------------------------------------------------------------
  // bus transactions
  // ----------------------------------------------------------------
  task automatic send(input string n, input logic [7:0] b, input logic e);
    logic a;
    m.send_byte(b, a);
    chk_bit(n, e, a);
  endtask

  task automatic wait_busy(input logic v);
    for (int i = 0; i < 3000 && busy !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk_bit("busy_level", v, busy);
  endtask

  task automatic straps(input logic md, input logic w);
    @(posedge clk);
    #1;
    mode_i = md;
    wi = w;
  endtask

  // full write; model address steps as the mode demands
  task automatic wr_cmd(input logic [2:0] blk, input logic [7:0] a,
                        input int n, input logic pg);
    m.start();
    send("sel_ack", {DEV_CODE_DEFAULT, blk, 1'b0}, 1'b1);
    send("addr_ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      dat_s = lfsr(dat_s);
      send("data_ack", dat_s, 1'b1);
      exp_q.push_back({blk, a, dat_s});
      a = pg ? {a[7:4], a[3:0] + 4'h1} : a + 8'h1;
    end
    m.stop();
    wait_busy(1'b1);
  endtask

  task automatic done_prog(input int tw);
    wait_busy(1'b0);
    @(posedge clk);
    #1;
    chk_int("busy_span", 1, int'(blen >= tw && blen < tw + SLACK));
    chk_int("words_left", 0, exp_q.size());
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    mode_i = 1'b1;
    wi = 1'b0;
    mem_wr_ready = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_bit("rst_sda_oe", 1'b0, sda_oe);
    chk_bit("rst_busy", 1'b0, busy);
    // byte write; inhibit strap has no say on this variant
    straps(1'b0, 1'b1);
    wr_cmd(3'h5, 8'ha7, 1, 1'b1);
    m.start();
    send("poll_busy", {DEV_CODE_DEFAULT, 3'h5, 1'b0}, 1'b0);
    m.stop();
    done_prog(TW_N);
    m.start();
    send("poll_done", {DEV_CODE_DEFAULT, 3'h0, 1'b0}, 1'b1);
    // foreign code, then read direction: both left unanswered
    m.start();
    send("foreign", {~DEV_CODE_DEFAULT, 3'h0, 1'b0}, 1'b0);
    m.start();
    send("read_dir", {DEV_CODE_DEFAULT, 3'h0, 1'b1}, 1'b0);
    m.stop();
    chk_bit("idle_busy", 1'b0, busy);
    // multibyte across rows, multibyte in one row, wrapping page
    straps(1'b1, 1'b0);
    wr_cmd(3'h2, 8'h0c, 8, 1'b0);
    done_prog(TW_L);
    wr_cmd(3'h3, 8'h20, 8, 1'b0);
    done_prog(TW_N);
    straps(1'b0, 1'b0);
    wr_cmd(3'h7, 8'h3e, 18, 1'b1);
    done_prog(TW_N);
    wrap_up();
  end

  // hang guard, well past the expected run length
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
endmodule

// ### verification/two_wire_master.sv
// bus master model for the two-wire eeprom port: clock and data pull
// assumes a pull-up on sda; the bench resolves the wire from all pulls

module two_wire_master (
  output logic     scl,
  output logic     sda_m,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // quarter of the 125 ns bus clock period
  localparam real Q = 31.25;

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  // idle bus: clock stands high, data released; only we clock the bus
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // start from idle or repeated start from a low clock
  task automatic start();
    sda_m = 1'b1;
    #(Q);
    scl = 1'b1;
    #(2*Q);
    sda_m = 1'b0;
    #(2*Q);
    scl = 1'b0;
  endtask

  // stop, then a bus free gap before anything new
  task automatic stop();
    #(Q);
    sda_m = 1'b0;
    #(Q);
    scl = 1'b1;
    #(2*Q);
    sda_m = 1'b1;
    #(4*Q);
  endtask

  // msb first; data moves only mid-way through the low clock phase
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(Q);
      sda_m = b[i];
      #(Q);
      scl = 1'b1;
      #(2*Q);
      scl = 1'b0;
    end
    // release for the ninth clock and read the receiver's pull
    #(Q);
    sda_m = 1'b1;
    #(Q);
    scl = 1'b1;
    #(Q);
    ack = !sda;
    #(Q);
    scl = 1'b0;
  endtask
endmodule
